// ===== hw/reader_protocol_timers.v
// timer unit of the reader front end: no-response, general purpose and wake-up timers
// assumes: ahb-lite slave; framing events are same-clock pulses; rc_clk_en is a
// pulse from the rc oscillator divider, qualified here by the oscillator request
// What this block does
// - no-response timer starts at end of transmission, awaits reply start
// - step bit picks no-response tick of 64 or 4096 carrier periods
// - default mode: timeout raises flag and drops receiver-active
// - default mode: reply start before timeout stops timer, no flag
// - unconditional mode: flag always on expiry; clear does not stop it
// - unconditional timeout drops receiver-active only if no reply in progress
// - no-response timeout has its own flag in the timer interrupt register
// - start command starts no-response timer, restarting if running
// - peer mode ignores the no-response start command
// - peer mode: timeout before peer field on raises flag
// - general timer triggered at sof or eof as set, flags expiry
// - peer mode: general timer times field switching off
// - start command starts general timer, restarting if running
// - wake-up start command accepted except in wake-up mode
// - wake-up start runs rc clock, expiry sets wake-up flag
// - only wake-up timer runs in low power; others are halted
// - clear stops all timers but wake-up, and unconditional no-response
//
// The address map and the AHB-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "timer_map.vh"
module reader_protocol_timers #(
   parameter NRT_WIDTH = 16,
   parameter GPT_WIDTH = 16,
   parameter WUT_WIDTH = 8
) (
   // ahb-lite slave
   input wire hclk,
   input wire hresetn,
   input wire hsel,
   input wire [7:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output reg [31:0] hrdata,
   output wire hreadyout,
   output wire hresp,
   // clock enables
   input wire carrier_clock,
   input wire rc_clk_en,
   // framing events
   input wire tx_end,
   input wire rx_sof,
   input wire rx_eof,
   input wire rx_busy,
   input wire peer_field_on,
   input wire peer_field_off,
   // outputs
   output reg rx_on,
   output wire rc_osc_on,
   output wire wakeup_expiry_flag
);
   // ************************************************************
   // registers
   // ************************************************************
   reg [6:0] ctrl;
   reg [NRT_WIDTH-1:0] nrt_dur;
   reg [GPT_WIDTH-1:0] gpt_dur;
   reg [WUT_WIDTH-1:0] wut_dur;
   reg [2:0] irq;
   reg wr_pend;
   reg rd_pend;
   reg [7:0] addr_q;
   reg [15:0] nrt_pre;
   reg [15:0] gpt_pre;
   reg reply_seen;
   reg car_s1, car_s2, car_s3;
   wire nrt_run, gpt_run, wut_run;
   wire nrt_exp, gpt_exp, wut_exp;

   function is_word;
      input [7:0] a;
      input [7:0] ofs;
      is_word = (a == ofs);
   endfunction

   // ************************************************************
   // bus slave: zero wait states, always okay
   // ************************************************************
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   wire take = hsel && hready && htrans[1];
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend <= 1'b0;
         rd_pend <= 1'b0;
         addr_q <= 8'h00;
      end else begin
         wr_pend <= take && hwrite;
         rd_pend <= take && !hwrite;
         if (take)
            addr_q <= haddr;
      end
   end
   wire cmd_wr = wr_pend && is_word(addr_q, `OFS_CMD);
   wire [7:0] cmd = hwdata[7:0];
   wire lowpwr = ctrl[`CTRL_LOWPWR];
   wire p2p = ctrl[`CTRL_P2P];
   wire uncond = ctrl[`CTRL_NRT_UNCOND];
   wire clear_cmd = cmd_wr && (cmd == `CMD_CLEAR);
   // write-one-to-clear; a flag set in the same cycle wins
   wire [2:0] irq_set = {wut_exp, gpt_exp, nrt_exp};
   wire [2:0] irq_clr = (wr_pend && is_word(addr_q, `OFS_IRQ)) ? hwdata[2:0] : 3'h0;
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl <= 7'h00;
         nrt_dur <= {NRT_WIDTH{1'b0}};
         gpt_dur <= {GPT_WIDTH{1'b0}};
         wut_dur <= {WUT_WIDTH{1'b0}};
         irq <= 3'h0;
      end else begin
         if (wr_pend && is_word(addr_q, `OFS_CTRL))
            ctrl <= hwdata[6:0];
         if (wr_pend && is_word(addr_q, `OFS_NRT))
            nrt_dur <= hwdata[NRT_WIDTH-1:0]; // stopped-only use assumed
         if (wr_pend && is_word(addr_q, `OFS_GPT))
            gpt_dur <= hwdata[GPT_WIDTH-1:0];
         if (wr_pend && is_word(addr_q, `OFS_WUT))
            wut_dur <= hwdata[WUT_WIDTH-1:0];
         irq <= (irq & ~irq_clr) | irq_set;
      end
   end
   // read mux, data held in a flop during the data phase
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0;
      end else if (take && !hwrite) begin
         case (haddr)
            `OFS_CTRL: hrdata <= {25'h0, ctrl};
            `OFS_NRT: hrdata <= {{(32-NRT_WIDTH){1'b0}}, nrt_dur};
            `OFS_GPT: hrdata <= {{(32-GPT_WIDTH){1'b0}}, gpt_dur};
            `OFS_WUT: hrdata <= {{(32-WUT_WIDTH){1'b0}}, wut_dur};
            `OFS_IRQ: hrdata <= {29'h0, irq};
            `OFS_STAT: hrdata <= {27'h0, rx_on, reply_seen, wut_run, gpt_run, nrt_run};
            default: hrdata <= 32'h0;
         endcase
      end
   end
   assign wakeup_expiry_flag = irq[`IRQ_WT];

   // ************************************************************
   // carrier tick prescaler
   // ************************************************************
   // carrier input is a pin: sync first, then edge detect on stages two and three
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         car_s1 <= 1'b0;
         car_s2 <= 1'b0;
         car_s3 <= 1'b0;
      end else begin
         car_s1 <= carrier_clock;
         car_s2 <= car_s1;
         car_s3 <= car_s2;
      end
   end
   // crystal stopped in low power, so no carrier ticks there
   wire car_edge = car_s2 && !car_s3 && !lowpwr;
   wire [15:0] nstep = ctrl[`CTRL_NRT_STEP] ? `NRT_STEP_LONG : `NRT_STEP_SHORT;

   // ************************************************************
   // no-response timer
   // ************************************************************
   // in peer mode the reply start is the peer switching its field on
   wire reply_start = p2p ? peer_field_on : rx_sof;
   wire nrt_cmd = cmd_wr && (cmd == `CMD_START_NRT) && !p2p;
   wire nrt_start = (tx_end && !lowpwr) || nrt_cmd;
   // default mode: reply start halts the timer before it can flag
   wire nrt_stop = (!uncond && reply_start) || (clear_cmd && !uncond) || lowpwr;
   // prescaler restarts with the timer so the first tick is a whole step, not a stub
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         nrt_pre <= 16'h0;
      else if (nrt_start)
         nrt_pre <= 16'h0;
      else if (car_edge)
         nrt_pre <= nrt_pre + 16'h1;
   end
   wire nrt_tick = car_edge && ((nrt_pre & (nstep - 16'h1)) == (nstep - 16'h1));
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         reply_seen <= 1'b0;
      else if (nrt_start)
         reply_seen <= 1'b0;
      else if (reply_start)
         reply_seen <= 1'b1;
   end
   tick_timer #(.WIDTH(NRT_WIDTH)) u_nrt (
      .hclk(hclk),
      .hresetn(hresetn),
      .start(nrt_start),
      .stop(nrt_stop),
      .tick(nrt_tick),
      .duration(nrt_dur),
      .running(nrt_run),
      .expire(nrt_exp) // flag raised in both modes and in peer mode
   );
   // receiver gating: open at end of transmission, forced low on timeout unless unconditional with a reply in progress
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         rx_on <= 1'b0;
      else if (nrt_exp && !(uncond && rx_busy))
         rx_on <= 1'b0;
      else if (tx_end)
         rx_on <= 1'b1;
   end

   // ************************************************************
   // general purpose timer
   // ************************************************************
   reg gpt_trig;
   always @* begin
      case (ctrl[`CTRL_GPT_TRIG_HI:`CTRL_GPT_TRIG_LO])
         `TRIG_SOF: gpt_trig = rx_sof;
         `TRIG_EOF: gpt_trig = rx_eof;
         `TRIG_FIELD: gpt_trig = p2p && peer_field_off;
         default: gpt_trig = 1'b0;
      endcase
   end
   wire gpt_start = (gpt_trig && !lowpwr) || (cmd_wr && (cmd == `CMD_START_GPT));
   // own prescaler, aligned to each start like the no-response one
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         gpt_pre <= 16'h0;
      else if (gpt_start)
         gpt_pre <= 16'h0;
      else if (car_edge)
         gpt_pre <= gpt_pre + 16'h1;
   end
   wire gpt_tick = car_edge && ((gpt_pre & (`GPT_STEP - 16'h1)) == (`GPT_STEP - 16'h1));
   tick_timer #(.WIDTH(GPT_WIDTH)) u_gpt (
      .hclk(hclk),
      .hresetn(hresetn),
      .start(gpt_start),
      .stop(clear_cmd || lowpwr),
      .tick(gpt_tick),
      .duration(gpt_dur),
      .running(gpt_run),
      .expire(gpt_exp)
   );

   // ************************************************************
   // wake-up timer on the rc oscillator enable
   // ************************************************************
   wire wut_start = cmd_wr && (cmd == `CMD_START_WUT) && !ctrl[`CTRL_WAKEMODE];
   assign rc_osc_on = wut_run; // rc oscillator requested while timing
   tick_timer #(.WIDTH(WUT_WIDTH)) u_wut (
      .hclk(hclk),
      .hresetn(hresetn),
      .start(wut_start),
      .stop(1'b0), // clear never stops it
      .tick(rc_clk_en && rc_osc_on),
      .duration(wut_dur),
      .running(wut_run),
      .expire(wut_exp)
   );
endmodule
`default_nettype wire

// ===== hw/timer_map.vh
// register offsets, field positions and timing counts of the timer unit
// assumes: included by the timer unit top, its port checker and the bench
`ifndef TIMER_MAP_VH
`define TIMER_MAP_VH
// ************************************************************
// register byte offsets
// ************************************************************
`define OFS_CTRL 8'h00
`define OFS_NRT 8'h04
`define OFS_GPT 8'h08
`define OFS_WUT 8'h0C
`define OFS_CMD 8'h10
`define OFS_IRQ 8'h14
`define OFS_STAT 8'h18
// ************************************************************
// control register fields
// ************************************************************
`define CTRL_NRT_STEP 0
`define CTRL_NRT_UNCOND 1
`define CTRL_GPT_TRIG_LO 2
`define CTRL_GPT_TRIG_HI 3
`define CTRL_P2P 4
`define CTRL_LOWPWR 5
`define CTRL_WAKEMODE 6
// general purpose trigger codes
`define TRIG_NONE 2'h0
`define TRIG_SOF 2'h1
`define TRIG_EOF 2'h2
`define TRIG_FIELD 2'h3
// ************************************************************
// command codes and interrupt flag positions
// ************************************************************
`define CMD_CLEAR 8'h01
`define CMD_START_NRT 8'h02
`define CMD_START_GPT 8'h03
`define CMD_START_WUT 8'h04
`define IRQ_NRE 0
`define IRQ_GPE 1
`define IRQ_WT 2
// ************************************************************
// tick sizes in carrier periods
// ************************************************************
`define NRT_STEP_SHORT 16'd64
`define NRT_STEP_LONG 16'd4096
`define GPT_STEP 16'd8
`endif

// ===== hw/tick_timer.v
// one down-counting timer that counts ticks and reports expiry
// assumes: tick is a one-cycle enable pulse on the same clock
`timescale 1ns/1ns
`default_nettype none
module tick_timer #(
   parameter WIDTH = 16
) (
   // clock and reset
   input wire hclk,
   input wire hresetn,
   // control
   input wire start,
   input wire stop,
   input wire tick,
   input wire [WIDTH-1:0] duration,
   // state
   output reg running,
   output reg expire
);
   reg [WIDTH-1:0] count;
   // start reloads even while running, so a restart extends the timeout
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         count <= {WIDTH{1'b0}};
         running <= 1'b0;
         expire <= 1'b0;
      end else begin
         expire <= 1'b0;
         if (start) begin
            count <= duration;
            running <= (duration != {WIDTH{1'b0}});
         end else if (stop) begin
            running <= 1'b0;
         end else if (running && tick) begin
            if (count <= {{(WIDTH-1){1'b0}}, 1'b1}) begin
               running <= 1'b0; // count reached: expire
               expire <= 1'b1;
            end else begin
               count <= count - {{(WIDTH-1){1'b0}}, 1'b1};
            end
         end
      end
   end
endmodule
`default_nettype wire

// ===== tb/timer_asserts.sv
// port checker of the timer unit
// assumes: bound to the timer top; a single clock domain
`timescale 1ns/1ns
`default_nettype none
`include "timer_map.vh"
module timer_asserts (
   // bus
   input wire hclk,
   input wire hresetn,
   input wire hsel,
   input wire [7:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire hready,
   input wire [31:0] hrdata,
   input wire hreadyout,
   input wire hresp,
   // framing and outputs
   input wire tx_end,
   input wire rx_busy,
   input wire rx_on,
   input wire rc_osc_on,
   input wire wakeup_expiry_flag
);
// ****
// assertions
// ****
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // taken transfers, seen in their address phase
   wire b_rd = hsel && hready && htrans[1] && !hwrite;
   wire b_wr = hsel && hready && htrans[1] && hwrite;
   wire irq_wr = b_wr && haddr == `OFS_IRQ;
   wire cmd_wr = b_wr && haddr == `OFS_CMD;
   AST_OKAY: assert property (hreadyout && !hresp)
      else $error("bus answer not okay with zero wait");
   AST_STAT_RD: assert property (b_rd && haddr == `OFS_STAT |=>
      hrdata[4] == $past(rx_on)) else $error("status misreports receiver");
   AST_IRQ_RD: assert property (b_rd && haddr == `OFS_IRQ |=>
      hrdata[2] == $past(wakeup_expiry_flag)) else $error("flag misread");
   AST_RX_SET: assert property (tx_end |=> rx_on)
      else $error("receiver not opened after transmit");
   AST_RX_RISE: assert property ($rose(rx_on) |-> $past(tx_end))
      else $error("receiver opened without transmit end");
   AST_RX_DROP: assert property ($fell(rx_on) |-> !$past(rx_busy))
      else $error("receiver closed during a reply");
   AST_WT_SET: assert property ($rose(wakeup_expiry_flag) |->
      $past(rc_osc_on) || $past(rc_osc_on, 2)) else $error("wake flag without timer");
   AST_WT_CLR: assert property ($fell(wakeup_expiry_flag) |-> $past(irq_wr, 2))
      else $error("wake flag lost without clear");
   AST_RC_START: assert property ($rose(rc_osc_on) |-> $past(cmd_wr, 2))
      else $error("oscillator started without command");
   AST_RC_STOP: assert property ($fell(rc_osc_on) |-> ##[0:2] wakeup_expiry_flag)
      else $error("wake timer stopped without flag");
endmodule
`default_nettype wire

// ===== tb/framing_model.sv
// stand-in for the analog side: carrier pin and rc oscillator divider
// assumes: hclk at 100 MHz; carrier kept below a quarter of hclk
`timescale 1ns/1ns
`default_nettype none
module framing_model #(
   parameter int CAR_HALF = 3,
   parameter int RC_DIV = 4
) (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // enables to the timer unit
   output logic carrier_clock,
   output logic rc_clk_en
);
// ****
// clock sources
// ****
   int cnt;
   // crystal side runs free; rc pulses are qualified by the unit itself
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt <= 0;
         carrier_clock <= 1'b0;
         rc_clk_en <= 1'b0;
      end else begin
         cnt <= cnt + 1;
         carrier_clock <= (cnt % (2 * CAR_HALF)) < CAR_HALF;
         rc_clk_en <= (cnt % RC_DIV) == 0;
      end
   end
endmodule
`default_nettype wire

// ===== tb/testbench.sv
// self-checking bench of the timer unit
// assumes: timer_map.vh on the include path; carrier period of 6 hclk cycles
`timescale 1ns/1ns
`default_nettype none
`include "timer_map.vh"
module testbench;
// ****
// stimulus and checking
// ****
   localparam int TN = 384; // short step: 64 carrier periods of 6 cycles
   logic hclk, hresetn, hsel, hwrite, rx_busy;
   logic [7:0] haddr;
   logic [1:0] htrans;
   logic [31:0] hwdata, hrdata, d;
   logic [4:0] ev;
   wire hreadyout, hresp, rx_on, rc_osc_on, wakeup_expiry_flag, carrier_clock, rc_clk_en;
   int mismatches, n_checks, i, n, g;
   int cyc = 0;
   int unsigned seed;
   reader_protocol_timers dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
      .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
      .carrier_clock, .rc_clk_en, .tx_end(ev[0]), .rx_sof(ev[1]), .rx_eof(ev[2]),
      .peer_field_on(ev[3]), .peer_field_off(ev[4]), .rx_busy, .rx_on, .rc_osc_on,
      .wakeup_expiry_flag);
   framing_model fm (.hclk, .hresetn, .carrier_clock, .rc_clk_en);
   task close_out;
      if (mismatches == 0 && n_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   // one single transfer; read data kept in d
   task bus(input logic w, input logic [7:0] a, input logic [31:0] v);
      @(posedge hclk);
      {hsel, htrans, haddr, hwrite} <= {1'b1, 2'h2, a, w};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      {hsel, htrans, hwdata} <= {1'b0, 2'h0, v};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      d = hrdata;
   endtask
   task wr(input logic [7:0] a, input logic [31:0] v);
      bus(1'b1, a, v);
   endtask
   task rchk(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(d, e);
   endtask
   task fire(input int k);
      @(posedge hclk);
      ev <= 5'h01 << k;
      @(posedge hclk);
      ev <= 5'h00;
   endtask
   task wt(input int c);
      repeat (c) @(posedge hclk);
   endtask
   function automatic int rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return int'(seed % 1000);
   endfunction
   initial begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end
   // hang guard, well above the longest expected run
   always @(posedge hclk) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         mismatches++;
         close_out;
      end
   end
   initial begin
      {hresetn, hsel, hwrite, rx_busy, ev, haddr, htrans, hwdata} = 0;
      {mismatches, n_checks, seed} = {32'h0, 32'h0, 32'h40};
      wt(10);
      hresetn <= 1'b1;
      // reset values; unmapped place ignores writes
      wr(8'h1C, 32'hFFFFFFFF);
      rchk(8'h1C, 32'h0);
      rchk(`OFS_IRQ, 32'h0);
      rchk(`OFS_STAT, 32'h0);
      // silent tag: count runs out and receiver closes
      n = 1 + rnd() % 3;
      wr(`OFS_NRT, 32'(n));
      fire(0); // transmit end taken in step with the timer
      wt(n * TN - 30);
      rchk(`OFS_STAT, 32'h11);
      wt(60);
      rchk(`OFS_IRQ, 32'h1);
      rchk(`OFS_STAT, 32'h0);
      // reply start in time halts the count
      wr(`OFS_IRQ, 32'h7);
      fire(0);
      wt(100);
      rx_busy <= 1'b1;
      fire(1);
      wt(n * TN);
      rchk(`OFS_IRQ, 32'h0);
      chk(32'(rx_on), 32'h1);
      // unconditional mode survives clear and a reply
      wr(`OFS_CTRL, 32'h2);
      fire(0);
      fire(1);
      wr(`OFS_CMD, `CMD_CLEAR);
      wt(n * TN + 40);
      rchk(`OFS_IRQ, 32'h1);
      chk(32'(rx_on), 32'h1);
      rx_busy <= 1'b0;
      wr(`OFS_IRQ, 32'h7);
      fire(0);
      wt(n * TN + 40);
      chk(32'(rx_on), 32'h0);
      rchk(`OFS_IRQ, 32'h1);
      // command restart extends the wait
      wr(`OFS_CTRL, 32'h0);
      wr(`OFS_IRQ, 32'h7);
      wr(`OFS_CMD, `CMD_START_NRT);
      wt(n * TN / 2);
      wr(`OFS_CMD, `CMD_START_NRT);
      wt(n * TN - 30);
      rchk(`OFS_IRQ, 32'h0);
      wt(60);
      rchk(`OFS_IRQ, 32'h1);
      // peer mode: command ignored, silent peer flagged
      wr(`OFS_CTRL, 32'h10);
      wr(`OFS_IRQ, 32'h7);
      wr(`OFS_CMD, `CMD_START_NRT);
      wt(n * TN + 40);
      rchk(`OFS_IRQ, 32'h0);
      fire(0);
      wt(n * TN + 40);
      rchk(`OFS_IRQ, 32'h1);
      // general timer: command and every trigger source
      for (i = 0; i < 4; i++) begin
         g = 2 + rnd() % 6;
         wr(`OFS_GPT, 32'(g));
         wr(`OFS_CTRL, 32'(i * 4 + (i == 3) * 16));
         wr(`OFS_IRQ, 32'h7);
         if (i == 0) wr(`OFS_CMD, `CMD_START_GPT);
         else fire(i == 3 ? 4 : i);
         wt(g * 48 - 20);
         rchk(`OFS_IRQ, 32'h0);
         wt(40);
         rchk(`OFS_IRQ, 32'h2);
      end
      // low power: only the wake timer counts
      wr(`OFS_CTRL, 32'h20);
      wr(`OFS_WUT, 32'h5);
      wr(`OFS_IRQ, 32'h7);
      wr(`OFS_CMD, `CMD_START_GPT);
      wr(`OFS_CMD, `CMD_START_WUT);
      wt(1);
      chk(32'(rc_osc_on), 32'h1);
      wt(600);
      rchk(`OFS_IRQ, 32'h4);
      chk(32'(wakeup_expiry_flag), 32'h1);
      // wake-up mode refuses the start command
      wr(`OFS_CTRL, 32'h40);
      wr(`OFS_IRQ, 32'h7);
      wr(`OFS_CMD, `CMD_START_WUT);
      wt(100);
      rchk(`OFS_IRQ, 32'h0);
      // long step: one tick of 4096 carrier periods
      wr(`OFS_CTRL, 32'h1);
      wr(`OFS_NRT, 32'h1);
      fire(0);
      wt(64 * TN - 100);
      rchk(`OFS_IRQ, 32'h0);
      wt(200);
      rchk(`OFS_IRQ, 32'h1);
      close_out;
   end
endmodule
bind reader_protocol_timers timer_asserts u_chk (.hclk, .hresetn, .hsel, .haddr, .htrans,
   .hwrite, .hready, .hrdata, .hreadyout, .hresp, .tx_end, .rx_busy, .rx_on, .rc_osc_on,
   .wakeup_expiry_flag);
`default_nettype wire
